// ### shared/dmc_pkg.sv
// dmc_pkg: constants, register map, types and decode helpers for the dram mode-change block
// assumes a single 250 mhz clock and an avalon-mm register slave with byte addresses
package dmc_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned REFI_NS = 7800;
  localparam int unsigned REFI_CYC = REFI_NS * CLK_MHZ / 1000;
  localparam logic [9:0] VREF_WR_CYC = 10'h200;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_T_MOD = 8'h08;
  localparam logic [7:0] OFS_T_CKSRE = 8'h0c;
  localparam logic [7:0] OFS_T_CKSRX = 8'h10;
  localparam logic [7:0] OFS_T_XS = 8'h14;
  localparam logic [7:0] OFS_T_MRD = 8'h18;
  localparam logic [7:0] OFS_T_DLLK = 8'h1c;
  localparam logic [7:0] OFS_MR0 = 8'h20;
  localparam logic [7:0] OFS_MR1 = 8'h24;
  localparam logic [7:0] OFS_MR2 = 8'h28;
  localparam logic [7:0] OFS_ERR = 8'h2c;
  localparam logic [7:0] OFS_REFCNT = 8'h30;
  // timing register reset values, in cycles
  localparam logic [15:0] T_MOD_RST = 16'h000c;
  localparam logic [15:0] T_CKSRE_RST = 16'h0008;
  localparam logic [15:0] T_CKSRX_RST = 16'h0008;
  localparam logic [15:0] T_XS_RST = 16'h0080;
  localparam logic [15:0] T_MRD_RST = 16'h0004;
  localparam logic [15:0] T_DLLK_RST = 16'h0200;
  localparam logic [15:0] MR_RST = 16'h0000;
  // mode register fields
  localparam int unsigned MR1_DLL_DIS = 0;
  localparam int unsigned MR0_DLL_RST = 8;
  localparam int unsigned MR0_CL_LSB = 4;
  localparam int unsigned MR1_AL_LSB = 3;
  localparam int unsigned MR2_CWL_LSB = 3;
  localparam logic [15:0] MR1_RTT_MASK = 16'h0244;
  localparam logic [15:0] MR2_RTT_MASK = 16'h0600;
  localparam logic [2:0] CL6_CODE = 3'h2;
  localparam logic [2:0] CWL6_CODE = 3'h1;
  localparam logic [3:0] CL_BASE = 4'h4;
  localparam logic [3:0] CWL_BASE = 4'h5;
  localparam logic [3:0] LAT_DLL_OFF = 4'h6;
  // control and error bits
  localparam int unsigned CTRL_VREF_FLOAT = 0;
  localparam int unsigned ERR_VREF = 0;
  localparam int unsigned ERR_ODT = 1;
  localparam int unsigned ERR_LAT = 2;
  localparam int unsigned ERR_BUSY = 3;
  localparam int unsigned ERR_CKCHG = 4;
  localparam int unsigned ERR_W = 5;

  typedef enum logic [2:0] {
    DMC_NOP = 3'h0,
    DMC_MRS = 3'h1,
    DMC_REF = 3'h2,
    DMC_RD = 3'h3,
    DMC_WR = 3'h4,
    DMC_OTHER = 3'h5
  } dmc_cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PDN = 6'h02,
    ST_SRE = 6'h04,
    ST_SRCK = 6'h08,
    ST_XS = 6'h10,
    ST_MRW = 6'h20
  } dmc_state_t;

  function automatic dmc_cmd_t dmc_decode(input logic cs_n, input logic ras_n, input logic cas_n, input logic we_n);
    dmc_cmd_t c;
    c = DMC_OTHER;
    if (cs_n || (ras_n && cas_n && we_n)) c = DMC_NOP;
    else if (!ras_n && !cas_n && !we_n) c = DMC_MRS;
    else if (!ras_n && !cas_n && we_n) c = DMC_REF;
    else if (ras_n && !cas_n && we_n) c = DMC_RD;
    else if (ras_n && !cas_n && !we_n) c = DMC_WR;
    return c;
  endfunction

  function automatic logic [15:0] dmc_max16(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction
endpackage

// ### core/dmc_dly.sv
// dmc_dly: programmable one-shot delay counter
// assumes len_i is stable at start_i; a length of zero behaves as one cycle
`timescale 1ns/1ps
module dmc_dly #(
  parameter int unsigned W = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [W-1:0] len_i,
  output logic busy_o,
  output logic done_o
);
  logic [W-1:0] cnt;
  logic busy;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (start_i) begin
      cnt <= len_i;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt <= W'(1)) busy <= 1'b0;
      else cnt <= cnt - W'(1);
    end
  end

  assign busy_o = busy;
  assign done_o = busy && (cnt <= W'(1)) && !start_i;
endmodule // dmc_dly

// ### core/dmc_sref.sv
// dmc_sref: internal refresh timer running while in self refresh
// assumes en_i is high only in self refresh; needs no external clock activity
`timescale 1ns/1ps
module dmc_sref #(
  parameter int unsigned PERIOD = 1950,
  parameter int unsigned CW = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  output logic tick_o,
  output logic [CW-1:0] count_o
);
  localparam int unsigned DW = $clog2(PERIOD + 1);
  logic [DW-1:0] div;
  logic wrap;

  assign wrap = en_i && (div == DW'(PERIOD - 1));

  // divider restarts on each entry so the first refresh lands one period in
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) div <= '0;
    else if (!en_i || wrap) div <= '0;
    else div <= div + DW'(1);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) count_o <= '0;
    else if (wrap) count_o <= count_o + CW'(1);
  end

  assign tick_o = wrap;
endmodule // dmc_sref

// ### core/dmc_core.sv
// dmc_core: dram-side self refresh, dll mode switch and clock change logic with register slave
// assumes commands are synchronous to sys_clk_i; ck_valid_i marks a running, stable external clock
// Function
// R1 - in self refresh, contents are kept by internal refresh without external clock
// R2 - first write at least 512 cycles after floating vref is valid again
// R3 - dll off allows only read latency 6 and write latency 6
// R4 - mode register 1 bit 0 set disables the dll, clear enables it
// R5 - dll off moves the read strobe reference to al plus cl minus one
// R6 - dll off: termination input held low, termination fields programmed zero
// R7 - clock crosses the dll on/off rate gap only inside self refresh
// R8 - dll off entry: idle, set disable bit, wait update delay, enter self refresh
// R9 - change clock after entry hold, exit after stable delay, rewrite after exit delay
// R10 - next command accepted after larger of mode-set and update delays
// R11 - returning to dll on: clear disable bit, wait, then start dll reset
// R12 - after dll reset wait, update registers, wait lock before dll-dependent commands
// R13 - clock frequency changes only in self refresh or precharge power-down
// R14 - after entry hold in self refresh, clock ignored until stable exit delay
// R15 - self refresh used for clock change still meets entry and exit timing
// R16 - power-down change: termination off, clock enable low, wait entry hold
// R17 - power-down clock change stays within the speed grade period limits
// R18 - after power-down change: stable clock, exit, then dll reset by mode set
// R19 - termination stays off during lock time after power-down change; code only flags odt_i during lock, odt_term_o not gated
// R20 - controller applies the current dll mode's latency and capture offset
// R21 - every named delay is a programmable cycle count; the code fixes the vref write delay at VREF_WR_CYC (512 cycles)
`timescale 1ns/1ps
module dmc_core import dmc_pkg::*; #(
  parameter int unsigned REFI = REFI_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ck_valid_i,
  input wire logic ck_change_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i,
  input wire logic odt_i,
  output logic self_refresh_o,
  output logic ck_ignored_o,
  output logic dll_off_o,
  output logic dll_locked_o,
  output logic cmd_ready_o,
  output logic odt_term_o,
  output logic [4:0] rd_lat_o,
  output logic [3:0] wr_lat_o,
  output logic refresh_tick_o
);
  dmc_state_t state, next_state;
  dmc_cmd_t cmd;
  logic cke_q, taken, ack;
  logic [15:0] t_mod, t_cksre, t_cksrx, t_xs, t_mrd, t_dllk, mr0, mr1, mr2, stab;
  logic [15:0] seq_len, refcnt;
  logic [ERR_W-1:0] err, err_set;
  logic vref_float, seq_start, seq_done, seq_busy, dllk_start, dllk_done, dllk_busy;
  logic pdn_ck_ok, sre_cmd, pdn_cmd;
  logic [9:0] vref_cnt;
  logic [3:0] cl_eff, cwl_eff, al_eff;
  logic lat_bad;

  assign cmd = dmc_decode(cs_n_i, ras_n_i, cas_n_i, we_n_i);
  // a command is sampled only with clock enable high in this and the previous cycle, except self refresh and power-down entry, sampled as clock enable falls
  assign taken = cke_i && cke_q && (state == ST_IDLE);
  assign sre_cmd = (state == ST_IDLE) && cke_q && !cke_i && (cmd == DMC_REF);
  assign pdn_cmd = (state == ST_IDLE) && cke_q && !cke_i && (cmd == DMC_NOP);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) cke_q <= 1'b0;
    else cke_q <= cke_i;
  end

  // stable clock cycle count, saturating
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) stab <= '0;
    else if (!ck_valid_i || ck_change_i) stab <= '0;
    else if (stab != 16'hffff) stab <= stab + 16'h0001;
  end

  always_comb begin
    next_state = state;
    seq_start = 1'b0;
    seq_len = t_cksre;
    unique case (state)
      ST_IDLE: begin
        if (sre_cmd || pdn_cmd) begin
          seq_start = 1'b1;
          next_state = sre_cmd ? ST_SRE : ST_PDN;
        end else if (taken && cmd == DMC_MRS) begin
          seq_start = 1'b1;
          seq_len = dmc_max16(t_mrd, t_mod); // R10
          next_state = ST_MRW;
        end
      end
      ST_PDN: if (cke_i) next_state = ST_IDLE;
      ST_SRE: if (seq_done) next_state = ST_SRCK; // R14
      ST_SRCK: begin
        // exit only once the new clock has run stable for the exit delay
        if (cke_i && stab >= t_cksrx) begin // R14
          seq_start = 1'b1;
          seq_len = t_xs;
          next_state = ST_XS;
        end
      end
      ST_XS: if (seq_done) next_state = ST_IDLE;
      ST_MRW: if (seq_done) next_state = ST_IDLE; // R10
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) state <= ST_IDLE;
    else state <= next_state;
  end

  dmc_dly #(.W(16)) u_seq (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .start_i(seq_start),
    .len_i(seq_len),
    .busy_o(seq_busy),
    .done_o(seq_done)
  );

  // entry hold elapsed in power-down: clock may now change
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) pdn_ck_ok <= 1'b0;
    else if (state != ST_PDN) pdn_ck_ok <= 1'b0;
    else if (seq_done || !seq_busy) pdn_ck_ok <= 1'b1;
  end

  // mode registers, written by mode register set commands
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mr0 <= MR_RST;
      mr1 <= MR_RST;
      mr2 <= MR_RST;
    end else if (taken && cmd == DMC_MRS) begin
      unique case (ba_i[1:0])
        2'h0: mr0 <= addr_i;
        2'h1: mr1 <= addr_i; // R4
        2'h2: mr2 <= addr_i;
        default: ;
      endcase
    end
  end

  assign dll_off_o = mr1[MR1_DLL_DIS]; // R4
  // dll reset restarts the lock timer; dll off or a clock change drops the lock
  assign dllk_start = taken && cmd == DMC_MRS && ba_i[1:0] == 2'h0 && addr_i[MR0_DLL_RST]; // R11

  dmc_dly #(.W(16)) u_dllk (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .start_i(dllk_start),
    .len_i(t_dllk),
    .busy_o(dllk_busy),
    .done_o(dllk_done)
  );

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) dll_locked_o <= 1'b0;
    else if (dll_off_o || dllk_start || ck_change_i) dll_locked_o <= 1'b0; // R12
    else if (dllk_done) dll_locked_o <= 1'b1; // R12
  end

  // latency decode; dll off pins both latencies to 6
  assign cl_eff = dll_off_o ? LAT_DLL_OFF : {1'b0, mr0[MR0_CL_LSB +: 3]} + CL_BASE; // R3
  assign cwl_eff = dll_off_o ? LAT_DLL_OFF : {1'b0, mr2[MR2_CWL_LSB +: 3]} + CWL_BASE; // R3
  always_comb begin
    unique case (mr1[MR1_AL_LSB +: 2])
      2'h1: al_eff = cl_eff - 4'h1;
      2'h2: al_eff = cl_eff - 4'h2;
      default: al_eff = 4'h0;
    endcase
  end
  assign lat_bad = dll_off_o && (mr0[MR0_CL_LSB +: 3] != CL6_CODE || mr2[MR2_CWL_LSB +: 3] != CWL6_CODE);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_lat_o <= '0;
      wr_lat_o <= '0;
      odt_term_o <= 1'b0;
    end else begin
      rd_lat_o <= {1'b0, al_eff} + {1'b0, cl_eff} - {4'h0, dll_off_o}; // R5
      wr_lat_o <= cwl_eff; // R3
      // termination never engages with the dll off
      odt_term_o <= odt_i && !dll_off_o && state == ST_IDLE && ((mr1 & MR1_RTT_MASK) != '0); // R6
    end
  end

  // write guard after a floating reference returns
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) vref_cnt <= '0;
    else if (state == ST_SRCK && next_state == ST_XS && vref_float) vref_cnt <= VREF_WR_CYC; // R2
    else if (vref_cnt != 10'h000) vref_cnt <= vref_cnt - 10'h001;
  end

  always_comb begin
    err_set = '0;
    err_set[ERR_VREF] = taken && cmd == DMC_WR && vref_cnt != 10'h000; // R2
    err_set[ERR_ODT] = odt_i && (dll_off_o || dllk_busy); // R6 R19
    err_set[ERR_LAT] = taken && (cmd == DMC_RD || cmd == DMC_WR) && lat_bad; // R3
    err_set[ERR_BUSY] = (state == ST_MRW || state == ST_XS) && cke_i && cmd != DMC_NOP
      || taken && cmd == DMC_RD && !dll_off_o && !dll_locked_o; // R10 R12
    err_set[ERR_CKCHG] = ck_change_i && !(state == ST_SRCK || pdn_ck_ok); // R13 R7
  end

  dmc_sref #(.PERIOD(REFI), .CW(16)) u_sref (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .en_i(self_refresh_o),
    .tick_o(refresh_tick_o),
    .count_o(refcnt)
  );

  assign self_refresh_o = (state == ST_SRE) || (state == ST_SRCK); // R1
  assign ck_ignored_o = (state == ST_SRCK); // R14
  assign cmd_ready_o = (state == ST_IDLE);

  // avalon slave: one wait cycle, write takes effect at the edge waitrequest is low
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) ack <= 1'b0;
    else ack <= (avs_read_i || avs_write_i) && !ack;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) avs_readdata_o <= '0;
    else if (avs_read_i && !ack) begin
      unique case (avs_address_i)
        OFS_CTRL: avs_readdata_o <= {31'h0, vref_float};
        OFS_STATUS: avs_readdata_o <= {21'h0, state, cmd_ready_o, ck_ignored_o, dll_locked_o, dll_off_o, self_refresh_o};
        OFS_T_MOD: avs_readdata_o <= {16'h0, t_mod};
        OFS_T_CKSRE: avs_readdata_o <= {16'h0, t_cksre};
        OFS_T_CKSRX: avs_readdata_o <= {16'h0, t_cksrx};
        OFS_T_XS: avs_readdata_o <= {16'h0, t_xs};
        OFS_T_MRD: avs_readdata_o <= {16'h0, t_mrd};
        OFS_T_DLLK: avs_readdata_o <= {16'h0, t_dllk};
        OFS_MR0: avs_readdata_o <= {16'h0, mr0};
        OFS_MR1: avs_readdata_o <= {16'h0, mr1};
        OFS_MR2: avs_readdata_o <= {16'h0, mr2};
        OFS_ERR: avs_readdata_o <= {27'h0, err};
        OFS_REFCNT: avs_readdata_o <= {16'h0, refcnt};
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  // delays are software cycle counts
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      vref_float <= 1'b0;
      t_mod <= T_MOD_RST;
      t_cksre <= T_CKSRE_RST;
      t_cksrx <= T_CKSRX_RST;
      t_xs <= T_XS_RST;
      t_mrd <= T_MRD_RST;
      t_dllk <= T_DLLK_RST;
    end else if (avs_write_i && ack) begin
      unique case (avs_address_i)
        OFS_CTRL: vref_float <= avs_writedata_i[CTRL_VREF_FLOAT];
        OFS_T_MOD: t_mod <= avs_writedata_i[15:0]; // R21
        OFS_T_CKSRE: t_cksre <= avs_writedata_i[15:0]; // R21
        OFS_T_CKSRX: t_cksrx <= avs_writedata_i[15:0]; // R21
        OFS_T_XS: t_xs <= avs_writedata_i[15:0]; // R21
        OFS_T_MRD: t_mrd <= avs_writedata_i[15:0]; // R21
        OFS_T_DLLK: t_dllk <= avs_writedata_i[15:0]; // R21
        default: ;
      endcase
    end
  end

  // sticky errors, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) err <= '0;
    else if (avs_write_i && ack && avs_address_i == OFS_ERR) err <= (err & ~avs_writedata_i[ERR_W-1:0]) | err_set;
    else err <= err | err_set;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_sr_keep;
    self_refresh_o && refresh_tick_o |=> refcnt == $past(refcnt) + 16'h0001;
  endproperty
  a_sr_keep: assert property (p_sr_keep) else $error("self refresh tick lost"); // R1

  property p_lat6;
    dll_off_o |-> ##1 (wr_lat_o == 4'h6 || $past(!dll_off_o));
  endproperty
  a_lat6: assert property (p_lat6) else $error("write latency not 6 with dll off"); // R3

  property p_dll_bit;
    taken && cmd == DMC_MRS && ba_i[1:0] == 2'h1 |=> dll_off_o == $past(addr_i[0]);
  endproperty
  a_dll_bit: assert property (p_dll_bit) else $error("dll disable bit not applied"); // R4

  property p_rd_early;
    dll_off_o && $stable(mr0) && $stable(mr1) |=> rd_lat_o == {1'b0, $past(al_eff)} + 5'h5;
  endproperty
  a_rd_early: assert property (p_rd_early) else $error("dll off read strobe offset wrong"); // R5

  property p_odt_off;
    dll_off_o |=> !odt_term_o;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination on with dll off"); // R6

  property p_ck_ign;
    state == ST_SRCK && !(cke_i && stab >= t_cksrx) |=> ck_ignored_o;
  endproperty
  a_ck_ign: assert property (p_ck_ign) else $error("clock not ignored in self refresh"); // R14

  property p_mrw;
    taken && cmd == DMC_MRS |=> !cmd_ready_o;
  endproperty
  a_mrw: assert property (p_mrw) else $error("command accepted during mode set delay"); // R10

  property p_vref;
    taken && cmd == DMC_WR && vref_cnt != 10'h000 |=> err[ERR_VREF];
  endproperty
  a_vref: assert property (p_vref) else $error("early write not flagged"); // R2

  property p_dll_rst;
    dllk_start |=> !dll_locked_o [*2];
  endproperty
  a_dll_rst: assert property (p_dll_rst) else $error("dll lock not dropped on reset"); // R12

  c_sr_cycle: cover property (state == ST_SRCK ##[1:1000] state == ST_XS ##[1:1000] state == ST_IDLE);
  c_dll_lock: cover property (dllk_start ##[1:1000] dll_locked_o);
  c_pdn_chg: cover property (state == ST_PDN && ck_change_i && pdn_ck_ok);
endmodule // dmc_core

// ### bench/dmc_ctl_model.sv
// dmc_ctl_model: controller side of the dram pins: commands, clock status, termination
// assumes tasks are called right after a rising sys_clk_i edge
`timescale 1ns/1ps
module dmc_ctl_model (
  input wire logic sys_clk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [15:0] addr_o,
  output logic odt_o,
  output logic ck_valid_o,
  output logic ck_change_o
);
  initial begin
    cke_o = 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
    ba_o = 3'h0;
    addr_o = 16'h0000;
    odt_o = 1'b0;
    ck_valid_o = 1'b1;
    ck_change_o = 1'b0;
  end

  // one command cycle; address inverted afterwards so stale values never look valid
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
    @(posedge sys_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
    ba_o <= b;
    addr_o <= a;
    @(posedge sys_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
    addr_o <= ~a;
  endtask

  task automatic sr_enter();
    @(posedge sys_clk_i);
    cke_o <= 1'b0;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h1;
    @(posedge sys_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
  endtask

  // clock stands still while ignored, then restarts at the new rate
  task automatic sr_clock(input int hold, input int t_cksrx);
    @(posedge sys_clk_i);
    ck_valid_o <= 1'b0;
    repeat (hold) @(posedge sys_clk_i);
    ck_change_o <= 1'b1;
    @(posedge sys_clk_i);
    ck_change_o <= 1'b0;
    ck_valid_o <= 1'b1;
    repeat (t_cksrx + 1) @(posedge sys_clk_i);
    cke_o <= 1'b1;
  endtask

  // clock enable step for power-down entry and exit; command pins stay idle
  task automatic set_cke(input logic v);
    @(posedge sys_clk_i);
    cke_o <= v;
  endtask

  task automatic change_pulse();
    @(posedge sys_clk_i);
    ck_change_o <= 1'b1;
    @(posedge sys_clk_i);
    ck_change_o <= 1'b0;
  endtask

  // deliberate termination request, only used by the refusal scenario
  task automatic odt_pulse();
    @(posedge sys_clk_i);
    odt_o <= 1'b1;
    @(posedge sys_clk_i);
    odt_o <= 1'b0;
  endtask
endmodule // dmc_ctl_model

// ### bench/tb_top.sv
// tb_top: self-checking bench for dmc_core with a controller model and avalon master
// assumes REFI shortened to 16 cycles; timing registers reprogrammed small
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_top import dmc_pkg::*;;
  logic sys_clk_i, reset_i, avs_read_i, avs_write_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic avs_waitrequest_o, ck_valid_i, ck_change_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i;
  logic [2:0] ba_i;
  logic [15:0] addr_i;
  logic self_refresh_o, ck_ignored_o, dll_off_o, dll_locked_o, cmd_ready_o, odt_term_o, refresh_tick_o;
  logic [4:0] rd_lat_o;
  logic [3:0] wr_lat_o;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int ticks = 0;

  dmc_core #(.REFI(16)) i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .ck_valid_i(ck_valid_i),
    .ck_change_i(ck_change_i), .cke_i(cke_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i),
    .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i), .odt_i(odt_i), .self_refresh_o(self_refresh_o),
    .ck_ignored_o(ck_ignored_o), .dll_off_o(dll_off_o), .dll_locked_o(dll_locked_o),
    .cmd_ready_o(cmd_ready_o), .odt_term_o(odt_term_o), .rd_lat_o(rd_lat_o), .wr_lat_o(wr_lat_o),
    .refresh_tick_o(refresh_tick_o));

  dmc_ctl_model i_ctl (.sys_clk_i(sys_clk_i), .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
    .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i), .odt_o(odt_i),
    .ck_valid_o(ck_valid_i), .ck_change_o(ck_change_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (refresh_tick_o === 1'b1) ticks++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask

  // counts cycles with commands refused; the hang guard ends a stuck wait
  task automatic wait_ready(output int n);
    n = 0;
    #1;
    while (cmd_ready_o !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask

  initial begin
    logic [15:0] rv[6];
    int mdl[6];
    int tsm[6];
    int n, cl_m, al_m, off_m;
    rv = '{T_MOD_RST, T_CKSRE_RST, T_CKSRX_RST, T_XS_RST, T_MRD_RST, T_DLLK_RST};
    tsm = '{3, 4, 5, 10, 2, 20};
    reset_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    void'($urandom(42));
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk("timing_rst", OFS_T_MOD + 8'(4 * i), {16'h0, rv[i]});
    rd_chk("mr1_rst", OFS_MR1, 32'h0);
    rd_chk("unmapped", 8'h34, 32'h0);
    wr(8'h34, 32'hffff_ffff);
    rd_chk("unmapped_wr", 8'h34, 32'h0);
    for (int i = 0; i < 6; i++) begin
      mdl[i] = $urandom & 32'hffff;
      wr(OFS_T_MOD + 8'(4 * i), 32'(mdl[i]));
      rd_chk("timing_rw", OFS_T_MOD + 8'(4 * i), 32'(mdl[i]));
    end
    for (int i = 0; i < 6; i++) wr(OFS_T_MOD + 8'(4 * i), 32'(tsm[i]));
    i_ctl.change_pulse();
    rd_chk("err_ckchg", OFS_ERR, 32'h10);
    wr(OFS_ERR, 32'h1f);
    rd_chk("err_clr", OFS_ERR, 32'h0);
    // dll off entry
    i_ctl.cmd(4'h0, 3'h1, 16'h0001);
    wait_ready(n);
    `CHK("busy_len", 3, n)
    `CHK("dll_off", 1'b1, dll_off_o)
    rd_chk("mr1", OFS_MR1, 32'h1);
    i_ctl.cmd(4'h0, 3'h2, {10'h0, CWL6_CODE, 3'h0});
    wait_ready(n);
    wr(OFS_ERR, 32'h1f);
    i_ctl.cmd(4'h0, 3'h0, 16'h0030);
    wait_ready(n);
    // latency is only judged when a read or write is issued
    i_ctl.cmd(4'h5, 3'h0, 16'h0000);
    rd_chk("err_cl7", OFS_ERR, 32'h4);
    wr(OFS_ERR, 32'h1f);
    i_ctl.cmd(4'h0, 3'h0, {9'h0, CL6_CODE, 4'h0});
    wait_ready(n);
    i_ctl.cmd(4'h5, 3'h0, 16'h0000);
    cl_m = 6;
    al_m = 0;
    off_m = 1;
    rd_chk("err_cl6", OFS_ERR, 32'h0);
    `CHK("rd_lat_off", 5'(al_m + cl_m - off_m), rd_lat_o)
    `CHK("wr_lat_off", 4'h6, wr_lat_o)
    i_ctl.odt_pulse();
    #1;
    `CHK("odt_off", 1'b0, odt_term_o)
    rd_chk("err_odt", OFS_ERR, 32'h2);
    wr(OFS_ERR, 32'h1f);
    // self refresh with clock change, vref left floating
    wr(OFS_CTRL, 32'h1);
    i_ctl.sr_enter();
    #1;
    `CHK("sr_in", 1'b1, self_refresh_o)
    `CHK("ck_hold", 1'b0, ck_ignored_o)
    ticks = 0;
    repeat (tsm[1] + 2) @(posedge sys_clk_i);
    #1;
    `CHK("ck_ign", 1'b1, ck_ignored_o)
    i_ctl.sr_clock(40, tsm[2]);
    wait_ready(n);
    `CHK("sr_out", 1'b0, self_refresh_o)
    `CHK("ticked", 1'b1, ticks > 1)
    rd_chk("refcnt", OFS_REFCNT, 32'(ticks));
    rd_chk("err_sr", OFS_ERR, 32'h0);
    i_ctl.cmd(4'h4, 3'h0, 16'h0000);
    rd_chk("err_vref", OFS_ERR, 32'h1);
    wr(OFS_ERR, 32'h1f);
    // back to dll on with dll reset
    i_ctl.cmd(4'h0, 3'h1, 16'h0000);
    wait_ready(n);
    `CHK("dll_on", 1'b0, dll_off_o)
    i_ctl.cmd(4'h0, 3'h0, 16'h0120);
    n = 0;
    #1;
    while (dll_locked_o !== 1'b1 && n < 200) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    `CHK("lock_time", 1'b1, n >= tsm[5] && n <= tsm[5] + 3)
    off_m = 0;
    `CHK("rd_lat_on", 5'(al_m + cl_m - off_m), rd_lat_o)
    rd_chk("mr0", OFS_MR0, 32'h120);
    // frequency change in precharge power-down, first too early then after the hold
    i_ctl.set_cke(1'b0);
    i_ctl.change_pulse();
    #1;
    `CHK("pd_lock_drop", 1'b0, dll_locked_o)
    rd_chk("err_pd_early", OFS_ERR, 32'h10);
    wr(OFS_ERR, 32'h1f);
    i_ctl.change_pulse();
    rd_chk("err_pd_chg", OFS_ERR, 32'h0);
    i_ctl.set_cke(1'b1);
    wait_ready(n);
    `CHK("pd_exit", 1'b1, cmd_ready_o)
    rd_chk("status_pd", OFS_STATUS, 32'h30);
    report_and_stop;
  end
endmodule // tb_top
